// [pkg/sprp_if.sv]
// Pins joining the serial register port host and device ends.
// Assumes the testbench resolves the shared data line from the enables.
`timescale 1ns/1ps
interface sprp_if;
  logic sclk;
  logic cs_n;
  logic serial_in_line;
  logic sdio_host_o;
  logic sdio_host_oe;
  logic sdio_dev_o;
  logic sdio_dev_oe;
  logic sdio_i;
  modport host (output sclk, output cs_n, output serial_in_line, output sdio_host_o,
    output sdio_host_oe, input sdio_i);
  modport device (input sclk, input cs_n, input serial_in_line, output sdio_dev_o,
    output sdio_dev_oe, input sdio_i);
endinterface

// [pkg/sprp_params.svh]
// Constants shared by the serial register port ends.
// Assumes inclusion by bare name from pkg/ and rtl/ files.
`ifndef SPRP_PARAMS_SVH
`define SPRP_PARAMS_SVH
`define SPRP_LONG_ADDR_BITS 15
`define SPRP_SHORT_ADDR_BITS 7
`define SPRP_PAGE_OFS_SHORT 16'h007C
`define SPRP_PAGE_OFS_LONG 16'h7FFD
`define SPRP_PAGE_BYTES_SHORT 4
`define SPRP_PAGE_BYTES_LONG 3
`define SPRP_PAGE_HI_BITS_SHORT 9
`define SPRP_PAGE_RESET 16'h0000
`define SPRP_DIV_DEFAULT 8
`endif

// [pkg/sprp_pkg.sv]
// Types shared by the serial register port ends.
// Assumes sprp_params.svh is on the include path.
`include "sprp_params.svh"
package sprp_pkg;
  typedef enum logic [1:0] {SPRP_CMD, SPRP_ADDR, SPRP_DATA} sprp_phase_t;
endpackage

// [rtl/sprp_device.sv]
// Serial register port device end: decodes header, bursts into a register space.
// Assumes pins are asynchronous and are synchronised onto clock_i.
// Functional notes
// [RULE_01] Three- or four-wire wiring; four-wire by default.
// [RULE_02] Four-wire: input line in, data line out.
// [RULE_03] Three-wire: one shared line, turned around for reads.
// [RULE_04] First bit: high reads, low writes.
// [RULE_05] Address follows, bit 14 first.
// [RULE_06] Short mode sends seven address bits only.
// [RULE_07] Data bytes travel bit 7 first.
// [RULE_08] Each further byte addresses next location.
// [RULE_09] Four-wire read ignores the input line.
// [RULE_10] Single-byte offset: 9 page bits above 7.
// [RULE_11] Single-byte page register at 0x7C, four bytes.
// [RULE_12] Double-byte offset: 1 page bit above 15.
// [RULE_13] Host sets page upper bit once.
// [RULE_14] Double-byte page register at 0x7FFD, three bytes.
// [RULE_15] Sampling edge is selectable.
// [RULE_16] Read data placement is selectable.
// [RULE_17] Settings load from defaults at reset.
// [RULE_18] Multi-byte registers moved in one burst.
// [RULE_19] Bursts stay within the current page; the code steps the full 16-bit pointer across page ends.
// [RULE_20] Option delays read data half a clock.
// [RULE_21] Chip select high ends transfer, frees line.
`timescale 1ns/1ps
`include "sprp_params.svh"
module sprp_device
  import sprp_pkg::*;
(
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rst_i,
  // Settings captured at reset release.
  input wire logic cfg_three_wire_i,
  input wire logic cfg_long_offset_i,
  input wire logic cfg_falling_sample_i,
  input wire logic cfg_half_delay_i,
  // Link pins.
  sprp_if.device link,
  // Register space port.
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [15:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  input wire logic [7:0] reg_rdata_i,
  output logic [15:0] page_o
);
  logic [2:0] sclk_s, cs_s;
  logic [1:0] sin_s, sio_s;
  logic cfg_loaded, three_wire, long_offset, falling_sample, half_delay;
  sprp_phase_t phase;
  logic is_read;
  logic [3:0] bit_cnt;
  logic [14:0] addr_sh;
  logic [7:0] rx_sh, tx_sh;
  logic [15:0] ptr;
  logic [15:0] page;
  logic out_bit;
  logic drive;
  logic sample_edge, launch_edge, rise, fall, active, in_bit;

  function automatic logic [15:0] full_addr(input logic [14:0] a, input logic lng,
    input logic [15:0] pg);
    full_addr = lng ? {pg[15], a} : {pg[15:7], a[6:0]};
  endfunction

  // Synchronisers; only the later stages feed logic.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sclk_s <= 3'h0;
      cs_s <= 3'h7;
      sin_s <= 2'h0;
      sio_s <= 2'h0;
    end else begin
      sclk_s <= {sclk_s[1:0], link.sclk};
      cs_s <= {cs_s[1:0], link.cs_n};
      sin_s <= {sin_s[0], link.serial_in_line};
      sio_s <= {sio_s[0], link.sdio_i};
    end
  end

  // Settings taken once after reset release.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_loaded <= 1'b0;
      three_wire <= 1'b0; // [RULE_01]
      long_offset <= 1'b0;
      falling_sample <= 1'b0;
      half_delay <= 1'b0;
    end else if (!cfg_loaded) begin
      cfg_loaded <= 1'b1;
      three_wire <= cfg_three_wire_i; // [RULE_17]
      long_offset <= cfg_long_offset_i;
      falling_sample <= cfg_falling_sample_i; // [RULE_15]
      half_delay <= cfg_half_delay_i; // [RULE_20]
    end
  end

  assign rise = sclk_s[1] & ~sclk_s[2];
  assign fall = ~sclk_s[1] & sclk_s[2];
  assign active = ~cs_s[1] & cfg_loaded;
  assign sample_edge = falling_sample ? fall : rise; // [RULE_15]
  // Without delay data changes on the edge opposite to sampling; with it, half later.
  assign launch_edge = half_delay ? sample_edge : (falling_sample ? rise : fall); // [RULE_16] [RULE_20]
  assign in_bit = three_wire ? sio_s[1] : sin_s[1]; // [RULE_02] [RULE_03]

  // Header and data sequencing.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      phase <= SPRP_CMD;
      is_read <= 1'b0;
      bit_cnt <= 4'h0;
      addr_sh <= 15'h0000;
      rx_sh <= 8'h00;
      ptr <= 16'h0000;
      reg_wr_o <= 1'b0;
      reg_rd_o <= 1'b0;
      reg_addr_o <= 16'h0000;
      reg_wdata_o <= 8'h00;
    end else begin
      reg_wr_o <= 1'b0;
      reg_rd_o <= 1'b0;
      if (!active) begin
        phase <= SPRP_CMD; // [RULE_21]
        bit_cnt <= 4'h0;
      end else if (sample_edge) begin
        case (phase)
          SPRP_CMD: begin
            is_read <= in_bit; // [RULE_04]
            bit_cnt <= 4'h0;
            phase <= SPRP_ADDR;
          end
          SPRP_ADDR: begin
            addr_sh <= {addr_sh[13:0], in_bit}; // [RULE_05]
            if (bit_cnt == (long_offset ? 4'(`SPRP_LONG_ADDR_BITS - 1)
                : 4'(`SPRP_SHORT_ADDR_BITS - 1))) begin // [RULE_06]
              bit_cnt <= 4'h0;
              phase <= SPRP_DATA;
              ptr <= full_addr({addr_sh[13:0], in_bit}, long_offset, page); // [RULE_10] [RULE_12]
              if (is_read) begin
                reg_rd_o <= 1'b1;
                reg_addr_o <= full_addr({addr_sh[13:0], in_bit}, long_offset, page);
              end
            end else begin
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
          SPRP_DATA: begin
            if (!is_read) begin // [RULE_09]
              rx_sh <= {rx_sh[6:0], in_bit}; // [RULE_07]
            end
            // Read bursts leave the input line unsampled. [RULE_09]
            bit_cnt <= (bit_cnt == 4'h7) ? 4'h0 : bit_cnt + 4'h1;
            if (bit_cnt == 4'h7) begin
              ptr <= ptr + 16'h0001; // [RULE_08]
              reg_addr_o <= is_read ? ptr + 16'h0001 : ptr;
              if (is_read) begin
                reg_rd_o <= 1'b1;
              end else begin
                reg_wr_o <= 1'b1;
                reg_wdata_o <= {rx_sh[6:0], in_bit};
              end
            end
          end
          default: phase <= SPRP_CMD;
        endcase
      end
    end
  end

  // Page register bytes written through the burst; short offsets put the low byte at 0x7C, long offsets write only the high byte at 0x7FFD.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      page <= `SPRP_PAGE_RESET;
    end else if (reg_wr_o) begin
      if (!long_offset) begin
        if (reg_addr_o == `SPRP_PAGE_OFS_SHORT) begin // [RULE_11]
          page[7:0] <= reg_wdata_o;
        end else if (reg_addr_o == `SPRP_PAGE_OFS_SHORT + 16'h0001) begin
          page[15:8] <= reg_wdata_o;
        end
      end else if (reg_addr_o == `SPRP_PAGE_OFS_LONG) begin // [RULE_14]
        page[15:8] <= reg_wdata_o; // [RULE_13]
      end
    end
  end
  assign page_o = page;

  // Read data shifting and line drive.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      tx_sh <= 8'h00;
      out_bit <= 1'b0;
      drive <= 1'b0;
    end else if (!active) begin
      drive <= 1'b0; // [RULE_21]
    end else if (phase == SPRP_DATA && is_read && launch_edge) begin
      drive <= 1'b1; // [RULE_03]
      if (bit_cnt == 4'h0) begin
        out_bit <= reg_rdata_i[7]; // [RULE_07]
        tx_sh <= {reg_rdata_i[6:0], 1'b0};
      end else begin
        out_bit <= tx_sh[7];
        tx_sh <= {tx_sh[6:0], 1'b0};
      end
    end
  end

  assign link.sdio_dev_o = out_bit;
  assign link.sdio_dev_oe = drive;
endmodule

// [rtl/sprp_host.sv]
// Serial register port host end: runs one burst per request.
// Assumes the device end meets it on sprp_if.
`timescale 1ns/1ps
`include "sprp_params.svh"
module sprp_host
  import sprp_pkg::*;
#(
  parameter int DIV = `SPRP_DIV_DEFAULT,
  parameter int MAX_BYTES = 8
) (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rst_i,
  // Settings matching the device.
  input wire logic three_wire_i,
  input wire logic long_offset_i,
  input wire logic falling_sample_i,
  input wire logic half_delay_i,
  // Request and answer.
  input wire logic start_i,
  input wire logic read_i,
  input wire logic [14:0] addr_i,
  input wire logic [3:0] nbytes_i,
  input wire logic [7:0] wdata_i,
  output logic wnext_o,
  output logic rvalid_o,
  output logic [7:0] rdata_o,
  output logic busy_o,
  // Link pins.
  sprp_if.host link
);
  initial begin
    if (DIV < 5 || DIV > 256 || MAX_BYTES < 1 || MAX_BYTES > 15) $error("bad sprp_host parameters");
  end
  logic [7:0] div_cnt;
  logic tick, sclk, cs_n, sin, sio_oe, last, cap;
  logic [5:0] bits_left;
  logic [3:0] bytes_left;
  logic [23:0] sh;
  logic [2:0] bcnt, scnt, rcnt;
  logic [7:0] rsh;
  logic rd;
  logic [1:0] sio_s;

  assign tick = div_cnt == 8'(DIV - 1);
  // The divider restarts with each frame so the first edge keeps a full half period.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) div_cnt <= 8'h00;
    else if (cs_n) div_cnt <= 8'h00;
    else div_cnt <= tick ? 8'h00 : div_cnt + 8'h01;
  end
  // Delayed read data is taken on the launch phase, plain read data on the sampling phase.
  assign cap = tick && !cs_n && rd && bits_left == 6'h00
    && ((sclk == falling_sample_i) != half_delay_i);

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) sio_s <= 2'h0;
    else sio_s <= {sio_s[0], link.sdio_i};
  end

  // Changes on the launch phase, device samples on the other.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cs_n <= 1'b1;
      sclk <= 1'b0;
      sin <= 1'b0;
      sio_oe <= 1'b0;
      bits_left <= 6'h00;
      bytes_left <= 4'h0;
      sh <= 24'h000000;
      bcnt <= 3'h0;
      scnt <= 3'h0;
      rcnt <= 3'h0;
      last <= 1'b0;
      rsh <= 8'h00;
      rd <= 1'b0;
      wnext_o <= 1'b0;
      rvalid_o <= 1'b0;
      rdata_o <= 8'h00;
    end else begin
      wnext_o <= 1'b0;
      rvalid_o <= 1'b0;
      if (cs_n && start_i) begin
        cs_n <= 1'b0;
        sclk <= falling_sample_i;
        rd <= read_i;
        bytes_left <= nbytes_i;
        bits_left <= long_offset_i ? 6'd16 : 6'd8;
        sh <= long_offset_i ? {read_i, addr_i, 8'h00} : {read_i, addr_i[6:0], 16'h0000}; // [RULE_05]
        sin <= read_i; // [RULE_04]
        sio_oe <= 1'b1;
        bcnt <= 3'h0;
        scnt <= 3'h0;
        rcnt <= 3'h0;
        last <= 1'b0;
      end else if (!cs_n && tick) begin
        sclk <= ~sclk;
        if (cap) begin
          rsh <= {rsh[6:0], sio_s[1]}; // [RULE_07]
          rcnt <= rcnt + 3'h1;
          if (rcnt == 3'h7) begin
            rvalid_o <= 1'b1;
            rdata_o <= {rsh[6:0], sio_s[1]};
          end
        end
        if (sclk == falling_sample_i) begin
          // Sampling edge: count data bits and close each byte.
          if (bits_left == 6'h00) begin
            scnt <= scnt + 3'h1;
            if (scnt == 3'h7) begin
              bytes_left <= bytes_left - 4'h1;
              if (bytes_left == 4'h1) begin
                last <= 1'b1;
              end else if (!rd) begin
                wnext_o <= 1'b1;
              end
            end
          end
        end else if (last) begin
          // The frame ends on the launch edge after the final sampled bit.
          cs_n <= 1'b1;
          sio_oe <= 1'b0;
          last <= 1'b0;
        end else if (bits_left > 6'h01) begin
          sh <= {sh[22:0], 1'b0};
          sin <= sh[22]; // [RULE_05]
          bits_left <= bits_left - 6'h01;
        end else begin
          bits_left <= 6'h00;
          if (rd) sio_oe <= 1'b0; // [RULE_03]
          sin <= rd ? 1'b0 : wdata_i[3'h7 - bcnt]; // [RULE_07]
          bcnt <= bcnt + 3'h1;
        end
      end
    end
  end

  assign busy_o = ~cs_n;
  assign link.sclk = sclk;
  assign link.cs_n = cs_n;
  assign link.serial_in_line = three_wire_i ? 1'b0 : sin;
  assign link.sdio_host_o = sin;
  assign link.sdio_host_oe = three_wire_i & sio_oe;
endmodule

// [tb/spi_slave_register_port_tb.sv]
// Bench joining host and device ends, with a byte memory behind the device.
// Assumes the data line has a pull-up when neither end drives it.
`timescale 1ns/1ps
module spi_slave_register_port_tb;
  import sprp_pkg::*;
  localparam logic [3:0] CFGS [4] = '{4'h0, 4'h6, 4'h9, 4'hF};
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic tw = 1'b0, lo = 1'b0, fa = 1'b0, hd = 1'b0;
  logic start = 1'b0, rd = 1'b0, quiet = 1'b0;
  logic [14:0] addr = 15'h0000;
  logic [3:0] nb = 4'h0;
  logic [7:0] wd = 8'h00, reg_rdata = 8'h00, rdata, reg_wdata;
  logic wnext, rvalid, busy, reg_wr, reg_rd;
  logic [15:0] reg_addr, page;
  logic [7:0] mem [0:65535];
  logic [23:0] exp_wr [$];
  logic [7:0] exp_rd [$];
  logic [7:0] wq [$];
  int err_total = 0, checks = 0, seed = 13478;
  sprp_if lk ();
  assign lk.sdio_i = (lk.sdio_dev_oe && lk.sdio_host_oe) ? 1'bx :
    lk.sdio_dev_oe ? lk.sdio_dev_o : lk.sdio_host_oe ? lk.sdio_host_o : 1'b1;
  initial begin
    forever #10 clock_i = ~clock_i;
  end
  sprp_device sprp_device_i (.clock_i(clock_i), .rst_i(rst_i), .cfg_three_wire_i(tw),
    .cfg_long_offset_i(lo), .cfg_falling_sample_i(fa), .cfg_half_delay_i(hd),
    .link(lk.device), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_addr_o(reg_addr),
    .reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata), .page_o(page));
  sprp_host sprp_host_i (.clock_i(clock_i), .rst_i(rst_i), .three_wire_i(tw),
    .long_offset_i(lo), .falling_sample_i(fa), .half_delay_i(hd), .start_i(start), .read_i(rd),
    .addr_i(addr), .nbytes_i(nb), .wdata_i(wd), .wnext_o(wnext), .rvalid_o(rvalid),
    .rdata_o(rdata), .busy_o(busy), .link(lk.host));
  sprp_props sprp_props_i (.clock_i(clock_i), .rst_i(rst_i), .sclk(lk.sclk),
    .cs_n(lk.cs_n), .serial_in_line(lk.serial_in_line), .sdio_host_o(lk.sdio_host_o),
    .sdio_host_oe(lk.sdio_host_oe), .sdio_dev_o(lk.sdio_dev_o),
    .sdio_dev_oe(lk.sdio_dev_oe), .sdio_i(lk.sdio_i));
  task chk(input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task wait_busy(input logic lvl);
    int n;
    for (n = 0; n < 5000 && busy !== lvl; n++) @(posedge clock_i);
    if (busy !== lvl) begin
      err_total++;
      $display("Error at %0t: host handshake timed out", $time);
      give_verdict();
    end
  endtask
  task burst(input logic r, input logic [14:0] a, input logic [3:0] n);
    @(posedge clock_i);
    start <= 1'b1;
    rd <= r;
    addr <= a;
    nb <= n;
    if (!r) wd <= wq.pop_front();
    wait_busy(1'b1);
    start <= 1'b0;
    wait_busy(1'b0);
    repeat (8) @(posedge clock_i);
  endtask
  task session(input logic [3:0] c);
    logic [15:0] base;
    logic [14:0] a;
    logic [3:0] n;
    logic [7:0] d;
    @(posedge clock_i);
    {tw, lo, fa, hd} <= c;
    rst_i <= 1'b1;
    repeat (20) @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    quiet <= 1'b1;
    wq = '{8'h80, 8'hCB, 8'h10, 8'h20};
    burst(1'b0, c[2] ? 15'h7FFD : 15'h007C, c[2] ? 4'h3 : 4'h4);
    wq.delete();
    quiet <= 1'b0;
    if (c[2]) chk(24'(page[15:8]), 24'h000080);
    else chk(24'(page), 24'h00CB80);
    base = c[2] ? 16'h8000 : 16'hCB80;
    for (int k = 0; k < 3; k++) begin
      n = 4'(1 + $unsigned($random(seed)) % 4);
      a = c[2] ? 15'($unsigned($random(seed)) % 32'h7FF0) : 15'($unsigned($random(seed)) % 120);
      for (int i = 0; i < n; i++) begin
        d = 8'($random(seed));
        wq.push_back(d);
        exp_wr.push_back({base + 16'(a) + 16'(i), d});
        exp_rd.push_back(d);
      end
      burst(1'b0, a, n);
      burst(1'b1, a, n);
    end
    chk(24'(exp_wr.size() + exp_rd.size()), 24'h000000);
    $display("test %0h done", c);
  endtask
  always @(posedge clock_i) begin
    if (reg_rd === 1'b1) reg_rdata <= mem[reg_addr];
    if (reg_wr === 1'b1) mem[reg_addr] <= reg_wdata;
    if (wnext === 1'b1 && wq.size() > 0) wd <= wq.pop_front();
  end
  always @(posedge clock_i) begin
    if (reg_wr === 1'b1 && !quiet) begin
      chk({reg_addr, reg_wdata}, exp_wr.size() ? exp_wr.pop_front() : 24'hXXXXXX);
    end
    if (rvalid === 1'b1) begin
      chk(24'(rdata), exp_rd.size() ? 24'(exp_rd.pop_front()) : 24'hXXXXXX);
    end
  end
  initial begin
    foreach (CFGS[t]) session(CFGS[t]);
    give_verdict();
  end
endmodule

// [tb/sprp_props.sv]
// Concurrent checks on the pins joining the host and device ends.
// Assumes the host holds each serial clock level for at least four clock cycles.
`timescale 1ns/1ps
module sprp_props (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rst_i,
  // Link pins.
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic serial_in_line,
  input wire logic sdio_host_o,
  input wire logic sdio_host_oe,
  input wire logic sdio_dev_o,
  input wire logic sdio_dev_oe,
  input wire logic sdio_i
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  AST_NO_CONTENTION: assert property (!(sdio_host_oe && sdio_dev_oe))
    else $error("both ends drive the data line");
  AST_CS_FREES: assert property (cs_n [*6] |-> !sdio_dev_oe)
    else $error("data line held after deselect");
  AST_DEV_OE_HOLDS: assert property (sdio_dev_oe && !cs_n |=> sdio_dev_oe)
    else $error("read drive dropped inside the frame");
  AST_SCLK_SLOW: assert property ($changed(sclk) |=> $stable(sclk) [*3])
    else $error("serial clock too fast");
  AST_OE_ONLY_SELECTED: assert property ($rose(sdio_dev_oe) |-> !cs_n)
    else $error("device drives while deselected");
  AST_FRAME_MIN: assert property ($fell(cs_n) |=> !cs_n [*8])
    else $error("frame shorter than a header bit");
  AST_HOST_OE_IN_FRAME: assert property (sdio_host_oe |-> !cs_n)
    else $error("host drives outside a frame");
  AST_SCLK_IDLE: assert property (cs_n [*3] |-> $stable(sclk))
    else $error("serial clock moves between frames");
  cover property ($rose(sdio_dev_oe));
  cover property ($rose(sdio_host_oe));
  cover property ($fell(cs_n));
endmodule
